// File: src/hbp_pkg.sv
package hbp_pkg;

	// host address space, byte addresses
	localparam int            HBP_ADDR_W      = 19;
	localparam int            HBP_DATA_W      = 16;
	localparam int            HBP_WORD_W      = 32;
	localparam logic [18:0] HBP_DMEM_BASE   = 19'h28000;
	localparam logic [18:0] HBP_IBER_BASE   = 19'h30000;
	localparam logic [18:0] HBP_INV1_BASE   = 19'h38000;
	localparam logic [18:0] HBP_BERC_BASE   = 19'h40000;
	localparam logic [18:0] HBP_GRP_BASE    = 19'h40200;
	localparam logic [18:0] HBP_IN_TIM_OFF  = 19'h40280;
	localparam logic [18:0] HBP_OUT_TIM_OFF = 19'h40284;
	localparam logic [18:0] HBP_INV2_BASE   = 19'h40290;

	// register field positions
	localparam int HBP_WORD_LSB  = 2;
	localparam int HBP_HALF_BIT  = 1;
	localparam int HBP_GRP_IDX_W = 5;

	// values after reset
	localparam logic [31:0] HBP_GRP_RESET     = 32'h000c000c;
	localparam logic [31:0] HBP_IN_TIM_RESET  = 32'h000000db;
	localparam logic [31:0] HBP_OUT_TIM_RESET = 32'h060d1c3c;

	// decoded target of an access
	typedef enum logic [2:0] {
		HBP_T_MEM_RW,
		HBP_T_MEM_RO,
		HBP_T_GRP,
		HBP_T_IN_TIM,
		HBP_T_OUT_TIM,
		HBP_T_INVALID
	} hbp_target_e;

	// port sequencer states
	typedef enum logic [2:0] {
		HBP_S_IDLE,
		HBP_S_ACCESS,
		HBP_S_DONE,
		HBP_S_HOLD,
		HBP_S_RELEASE
	} hbp_state_e;

endpackage : hbp_pkg

// File: src/hbp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface hbp_sync_if;
	logic cs_raw_n;
	logic ds_raw_n;
	logic cs_n;
	logic ds_n;

	modport sync (input cs_raw_n, input ds_raw_n, output cs_n, output ds_n);
	modport core (output cs_raw_n, output ds_raw_n, input cs_n, input ds_n);
endinterface : hbp_sync_if

`default_nettype wire

// File: src/hbp_strobe_sync.sv
`timescale 1ns/1ps
`default_nettype none

module hbp_strobe_sync (
	// clock and resets
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic power_on_reset_n,
	// strobes
	hbp_sync_if.sync  sy
);

	logic [1:0] stage1_reg;
	logic [1:0] stage2_reg;

	// two flops per strobe
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			stage1_reg <= 2'h3;
			stage2_reg <= 2'h3;
		end else begin
			stage1_reg <= {sy.cs_raw_n, sy.ds_raw_n};
			stage2_reg <= stage1_reg;
		end
	end

	assign sy.cs_n = stage2_reg[1];
	assign sy.ds_n = stage2_reg[0];

endmodule : hbp_strobe_sync

`default_nettype wire

// File: src/hbp_host_port.sv
// Notes on behaviour
// (RL1) host data bit 15 maps to 31/15
// (RL2) style pin picks handshake style
// (RL3) wait and acknowledge provided in both styles
// (RL4) each 32-bit location spans four bytes
// (RL5) lowest byte address is most significant
// (RL6) decode 19 address bits, ignore lowest
// (RL7) lane enables active low, strobe or enable
// (RL8) half select: 0 upper, 1 lower half
// (RL9) single lane picks one byte of half
// (RL10) host drives read setup then strobe
// (RL11) wait held low until access completes
// (RL12) read drives all sixteen data pins
// (RL13) release wait in same cycle as acknowledge or error
// (RL14) host ends cycle on termination seen
// (RL15) strobe high returns ack/error high
// (RL16) select high tristates data and controls
// (RL17) early select release drives high first
// (RL18) byte-enable style always acknowledges
// (RL19) host drives write setup then strobe
// (RL20) valid write stores enabled lanes
// (RL21) unused or read-only writes discarded
// (RL22) read-only writes, invalid ranges: error
// (RL23) no master clock: always bus error
// (RL24) power-on reset holds port asynchronously
// (RL25) strobes synchronised, read data held
`timescale 1ns/1ps
`default_nettype none

module hbp_host_port
	import hbp_pkg::*;
#(
	parameter int GROUPS = 32
) (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        power_on_reset_n,
	// host bus controls
	input  wire logic        bus_style_select,
	input  wire logic        chip_select_n,
	input  wire logic        data_strobe_n,
	input  wire logic        read_not_write,
	input  wire logic [18:0] host_address,
	input  wire logic        upper_lane_en_n,
	input  wire logic        lower_lane_en_n,
	// host data pin
	input  wire logic [15:0] host_data_in,
	output logic      [15:0] host_data_out,
	output logic             host_data_oe,
	// cycle termination pins
	output logic             cycle_wait_n_out,
	output logic             cycle_wait_n_oe,
	output logic             transfer_ack_n_out,
	output logic             transfer_ack_n_oe,
	output logic             bus_error_n_out,
	output logic             bus_error_n_oe,
	// core status
	input  wire logic        master_clock_ok,
	// memory port to core storage
	output logic      [16:0] mem_word_addr,
	output logic             mem_read_only,
	output logic             mem_wr_en,
	output logic      [3:0]  mem_byte_en,
	output logic      [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	// register contents to core
	output logic      [31:0] input_timing_control,
	output logic      [31:0] output_timing_control,
	output logic      [31:0] stream_group0_control
);

	// address decode
	function automatic hbp_target_e decode(input logic [18:0] a);
		hbp_target_e t;
		t = HBP_T_INVALID;
		if (a < HBP_DMEM_BASE)
			t = HBP_T_MEM_RW;
		else if (a < HBP_IBER_BASE)
			t = HBP_T_MEM_RO;
		else if (a < HBP_INV1_BASE)
			t = HBP_T_MEM_RW;
		else if (a < HBP_BERC_BASE)
			t = HBP_T_INVALID;
		else if (a < HBP_GRP_BASE)
			t = HBP_T_MEM_RW;
		else if (a < HBP_IN_TIM_OFF)
			t = HBP_T_GRP;
		else if (a < HBP_OUT_TIM_OFF)
			t = HBP_T_IN_TIM;
		else if (a < HBP_OUT_TIM_OFF + 19'h4)
			t = HBP_T_OUT_TIM;
		else if (a < HBP_INV2_BASE)
			t = HBP_T_MEM_RW;
		return t;
	endfunction : decode

	// byte mask, bit 3 = bits 31:24
	function automatic logic [3:0] byte_mask(input logic half,
			input logic up_n, input logic lo_n);
		logic [1:0] lanes;
		lanes = {~up_n, ~lo_n};
		return half ? {2'h0, lanes} : {lanes, 2'h0};
	endfunction : byte_mask

	// merge host half-word into a word
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [15:0] d, input logic [3:0] m);
		logic [31:0] wide;
		logic [31:0] res;
		wide = {d, d};
		for (int i = 0; i < 4; i++) begin
			res[i*8 +: 8] = m[i] ? wide[i*8 +: 8] : old[i*8 +: 8];
		end
		return res;
	endfunction : merge

	hbp_sync_if sif ();

	hbp_state_e  state_reg;
	hbp_target_e target_reg;
	logic [18:0] addr_reg;
	logic        rnw_reg;
	logic        style_reg;
	logic        clk_ok_reg;
	logic [3:0]  mask_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic        data_oe_reg;
	logic        drive_reg;
	logic        wait_n_reg;
	logic        ack_n_reg;
	logic        bus_error_n_n_reg;
	logic [31:0] grp_reg [GROUPS];
	logic [31:0] in_tim_reg;
	logic [31:0] out_tim_reg;

	logic [HBP_GRP_IDX_W-1:0] grp_idx;
	logic        word_half_select;
	logic        byte_addr_lsb_unused;
	logic        access_err;
	logic        write_ok;
	logic [31:0] cur_word;
	logic [15:0] half_word;

	assign sif.cs_raw_n = chip_select_n;
	assign sif.ds_raw_n = data_strobe_n;

	hbp_strobe_sync u_sync (
		.clk              (clk),
		.rst              (rst),
		.power_on_reset_n (power_on_reset_n),
		.sy               (sif.sync)
	); // [RL25]

	assign word_half_select     = addr_reg[HBP_HALF_BIT]; // [RL8]
	assign byte_addr_lsb_unused = addr_reg[0]; // [RL6]
	assign grp_idx = addr_reg[HBP_WORD_LSB +: HBP_GRP_IDX_W];

	// error: no clock, invalid space, read-only write
	always_comb begin
		access_err = !clk_ok_reg; // [RL23]
		if (target_reg == HBP_T_INVALID)
			access_err = 1'b1; // [RL22]
		if (target_reg == HBP_T_MEM_RO && !rnw_reg)
			access_err = 1'b1; // [RL22]
	end

	assign write_ok = !rnw_reg && !access_err; // [RL21]

	// addressed word, any storage
	always_comb begin
		cur_word = mem_rdata;
		unique case (target_reg)
			HBP_T_GRP:     cur_word = grp_reg[grp_idx];
			HBP_T_IN_TIM:  cur_word = in_tim_reg;
			HBP_T_OUT_TIM: cur_word = out_tim_reg;
			HBP_T_MEM_RW,
			HBP_T_MEM_RO,
			HBP_T_INVALID: cur_word = mem_rdata;
		endcase
	end

	// host bit 15 maps to bit 31 or 15
	assign half_word = word_half_select ? cur_word[15:0]
		: cur_word[31:16]; // [RL1] [RL5]

	// memory port, one write pulse in access state
	assign mem_word_addr = addr_reg[18:HBP_WORD_LSB]; // [RL4]
	assign mem_read_only = target_reg == HBP_T_MEM_RO;
	assign mem_byte_en   = mask_reg;
	assign mem_wdata     = {wdata_reg, wdata_reg};
	assign mem_wr_en     = state_reg == HBP_S_ACCESS && write_ok
		&& target_reg == HBP_T_MEM_RW; // [RL20]

	// sequencer
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			state_reg <= HBP_S_IDLE; // [RL24]
		end else begin
			unique case (state_reg)
				HBP_S_IDLE:
					if (!sif.cs_n && !sif.ds_n)
						state_reg <= HBP_S_ACCESS;
				HBP_S_ACCESS:
					state_reg <= HBP_S_DONE;
				HBP_S_DONE:
					if (sif.cs_n)
						state_reg <= HBP_S_RELEASE; // [RL17]
					else if (sif.ds_n)
						state_reg <= HBP_S_HOLD;
				HBP_S_HOLD:
					if (sif.cs_n)
						state_reg <= HBP_S_IDLE;
				HBP_S_RELEASE:
					state_reg <= HBP_S_IDLE;
			endcase
		end
	end

	// request capture at cycle start
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			target_reg <= HBP_T_INVALID;
			addr_reg   <= 19'h0;
			rnw_reg    <= 1'b1;
			style_reg  <= 1'b0;
			clk_ok_reg <= 1'b0;
			mask_reg   <= 4'h0;
			wdata_reg  <= 16'h0;
		end else if (state_reg == HBP_S_IDLE && !sif.cs_n && !sif.ds_n) begin
			target_reg <= decode(host_address); // [RL6]
			addr_reg   <= host_address;
			rnw_reg    <= read_not_write;
			style_reg  <= bus_style_select; // [RL2]
			clk_ok_reg <= master_clock_ok;
			mask_reg   <= byte_mask(host_address[HBP_HALF_BIT],
				upper_lane_en_n, lower_lane_en_n); // [RL7] [RL9]
			wdata_reg  <= host_data_in;
		end
	end

	// read data, held until the next access
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			rdata_reg <= 16'h0;
		end else if (state_reg == HBP_S_ACCESS) begin
			rdata_reg <= half_word; // [RL12] [RL25]
		end
	end

	// data pin enable for reads
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			data_oe_reg <= 1'b0;
		end else if (state_reg == HBP_S_IDLE && !sif.cs_n && !sif.ds_n) begin
			data_oe_reg <= read_not_write; // [RL12]
		end else if (state_reg != HBP_S_IDLE && state_reg != HBP_S_ACCESS
				&& sif.cs_n) begin
			data_oe_reg <= 1'b0; // [RL16]
		end
	end

	// termination pins
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			drive_reg  <= 1'b0;
			wait_n_reg <= 1'b1;
			ack_n_reg  <= 1'b1;
			bus_error_n_n_reg <= 1'b1;
		end else begin
			unique case (state_reg)
				HBP_S_IDLE:
					if (!sif.cs_n && !sif.ds_n) begin
						drive_reg  <= 1'b1; // [RL3]
						wait_n_reg <= 1'b0; // [RL11]
					end
				HBP_S_ACCESS: begin
					wait_n_reg <= 1'b1; // [RL13]
					bus_error_n_n_reg <= !access_err; // [RL13] [RL22]
					ack_n_reg  <= access_err && !style_reg; // [RL18]
				end
				HBP_S_DONE:
					if (sif.cs_n) begin
						ack_n_reg  <= 1'b1; // [RL17]
						bus_error_n_n_reg <= 1'b1;
						wait_n_reg <= 1'b1;
					end else if (sif.ds_n) begin
						ack_n_reg  <= 1'b1; // [RL15]
						bus_error_n_n_reg <= 1'b1;
					end
				HBP_S_HOLD:
					if (sif.cs_n)
						drive_reg <= 1'b0; // [RL16]
				HBP_S_RELEASE:
					drive_reg <= 1'b0; // [RL17]
			endcase
		end
	end

	// group control registers
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			for (int i = 0; i < GROUPS; i++) begin
				grp_reg[i] <= HBP_GRP_RESET;
			end
		end else if (state_reg == HBP_S_ACCESS && write_ok
				&& target_reg == HBP_T_GRP) begin
			grp_reg[grp_idx] <= merge(grp_reg[grp_idx], wdata_reg,
				mask_reg); // [RL20]
		end
	end

	// timing control registers
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n || rst) begin
			in_tim_reg  <= HBP_IN_TIM_RESET;
			out_tim_reg <= HBP_OUT_TIM_RESET;
		end else if (state_reg == HBP_S_ACCESS && write_ok) begin
			if (target_reg == HBP_T_IN_TIM)
				in_tim_reg <= merge(in_tim_reg, wdata_reg,
					mask_reg); // [RL20]
			if (target_reg == HBP_T_OUT_TIM)
				out_tim_reg <= merge(out_tim_reg, wdata_reg,
					mask_reg); // [RL20]
		end
	end

	// pins
	assign host_data_out      = rdata_reg;
	assign host_data_oe       = data_oe_reg;
	assign cycle_wait_n_out   = wait_n_reg;
	assign cycle_wait_n_oe    = drive_reg;
	assign transfer_ack_n_out = ack_n_reg;
	assign transfer_ack_n_oe  = drive_reg;
	assign bus_error_n_out    = bus_error_n_n_reg;
	assign bus_error_n_oe     = drive_reg;

	assign input_timing_control  = in_tim_reg;
	assign output_timing_control = out_tim_reg;
	assign stream_group0_control = grp_reg[0];

endmodule : hbp_host_port

`default_nettype wire

// File: bench/hbp_host_port_props.sv
`timescale 1ns/1ps
`default_nettype none

module hbp_host_port_props (
	// clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic power_on_reset_n,
	// host controls
	input wire logic bus_style_select,
	input wire logic chip_select_n,
	input wire logic data_strobe_n,
	input wire logic master_clock_ok,
	// termination pins
	input wire logic cycle_wait_n_out,
	input wire logic cycle_wait_n_oe,
	input wire logic transfer_ack_n_out,
	input wire logic bus_error_n_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !power_on_reset_n);

	wait_pulse_a: assert property (
		$fell(cycle_wait_n_out) |=> cycle_wait_n_out)
		else $error("wait low too long");
	wait_start_a: assert property (
		$fell(cycle_wait_n_out) |->
		$past(!chip_select_n, 2) && $past(!data_strobe_n, 2))
		else $error("wait without synced strobe");
	term_one_a: assert property (
		$rose(cycle_wait_n_out) && !bus_style_select |->
		transfer_ack_n_out != bus_error_n_out)
		else $error("not one termination");
	byte_ack_a: assert property (
		$rose(cycle_wait_n_out) && bus_style_select |-> !transfer_ack_n_out)
		else $error("no ack in byte style");
	no_clk_a: assert property (
		$rose(cycle_wait_n_out) && !master_clock_ok |-> !bus_error_n_out)
		else $error("no error without clock");
	ds_end_a: assert property (
		data_strobe_n [*4] |=> transfer_ack_n_out && bus_error_n_out)
		else $error("termination held after strobe");
	cs_end_a: assert property (
		chip_select_n [*6] |-> !cycle_wait_n_oe)
		else $error("pins driven after select");
	drive_high_a: assert property (
		$fell(cycle_wait_n_oe) |-> $past(cycle_wait_n_out) &&
		$past(transfer_ack_n_out) && $past(bus_error_n_out))
		else $error("released while low");

	cover property ($rose(cycle_wait_n_out) && !bus_error_n_out);
	cover property ($rose(cycle_wait_n_out) && bus_style_select);
	cover property ($fell(cycle_wait_n_oe) && !data_strobe_n);
endmodule : hbp_host_port_props

bind hbp_host_port hbp_host_port_props hbp_host_port_props_i (
	.clk(clk), .rst(rst), .power_on_reset_n(power_on_reset_n),
	.bus_style_select(bus_style_select), .chip_select_n(chip_select_n),
	.data_strobe_n(data_strobe_n), .master_clock_ok(master_clock_ok),
	.cycle_wait_n_out(cycle_wait_n_out), .cycle_wait_n_oe(cycle_wait_n_oe),
	.transfer_ack_n_out(transfer_ack_n_out),
	.bus_error_n_out(bus_error_n_out));

`default_nettype wire

// File: bench/hbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module hbp_host_model (
	// clock
	input wire logic         clk,
	// host bus controls
	output logic             chip_select_n,
	output logic             data_strobe_n,
	output logic             read_not_write,
	output logic [18:0]      host_address,
	output logic             upper_lane_en_n,
	output logic             lower_lane_en_n,
	output logic [15:0]      host_data_in,
	// device answers, pin levels
	input wire logic [15:0]  host_data_out,
	input wire logic         ack_n,
	input wire logic         bus_error_n_n
);
	initial begin
		chip_select_n = 1;
		data_strobe_n = 1;
		read_not_write = 1;
		host_address = 19'h00000;
		{upper_lane_en_n, lower_lane_en_n} = 2'b11;
		host_data_in = 16'h0000;
	end

	task automatic cyc(input logic rnw, input logic [18:0] a,
		input logic [1:0] ln, input logic [15:0] wd, input logic early,
		output logic [15:0] rd, output logic ak, output logic be);
		int n;
		@(posedge clk);
		#1;
		read_not_write = rnw;
		host_address = a;
		{upper_lane_en_n, lower_lane_en_n} = ln;
		host_data_in = rnw ? ~host_data_in : wd;
		chip_select_n = 0;
		@(posedge clk);
		#1;
		data_strobe_n = 0;
		n = 0;
		while (ack_n && bus_error_n_n && n < 50) begin
			@(posedge clk);
			n++;
		end
		rd = host_data_out;
		ak = ack_n;
		be = bus_error_n_n;
		#1;
		if (early) chip_select_n = 1;
		else data_strobe_n = 1;
		repeat (6) @(posedge clk);
		#1;
		chip_select_n = 1;
		data_strobe_n = 1;
		repeat (6) @(posedge clk);
	endtask : cyc
endmodule : hbp_host_model

`default_nettype wire

// File: bench/hbp_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

module hbp_host_port_bench;
	import hbp_pkg::*;
	logic        clk, rst, power_on_reset_n, bus_style_select, master_clock_ok;
	logic        cs_n, ds_n, rnw, up_n, lo_n;
	logic [18:0] addr;
	logic [15:0] wd, dout, rd;
	logic        d_oe, w_o, w_oe, a_o, a_oe, e_o, e_oe, ak, be;
	logic [31:0] mem_rdata, itc, otc, grp;
	logic [16:0] m_addr;
	logic        m_ro, m_we;
	logic [3:0]  m_be;
	logic [31:0] m_wd;
	int          checked, n_mismatch, cycles, n_wr, n_wait;

	hbp_host_port hbp_host_port_i (
		.clk(clk), .rst(rst), .power_on_reset_n(power_on_reset_n),
		.bus_style_select(bus_style_select), .chip_select_n(cs_n),
		.data_strobe_n(ds_n), .read_not_write(rnw), .host_address(addr),
		.upper_lane_en_n(up_n), .lower_lane_en_n(lo_n),
		.host_data_in(wd), .host_data_out(dout), .host_data_oe(d_oe),
		.cycle_wait_n_out(w_o), .cycle_wait_n_oe(w_oe),
		.transfer_ack_n_out(a_o), .transfer_ack_n_oe(a_oe),
		.bus_error_n_out(e_o), .bus_error_n_oe(e_oe),
		.master_clock_ok(master_clock_ok), .mem_word_addr(m_addr),
		.mem_read_only(m_ro), .mem_wr_en(m_we), .mem_byte_en(m_be),
		.mem_wdata(m_wd),
		.mem_rdata(mem_rdata), .input_timing_control(itc),
		.output_timing_control(otc), .stream_group0_control(grp));

	hbp_host_model hbp_host_model_i (
		.clk(clk), .chip_select_n(cs_n), .data_strobe_n(ds_n),
		.read_not_write(rnw), .host_address(addr), .upper_lane_en_n(up_n),
		.lower_lane_en_n(lo_n), .host_data_in(wd),
		.host_data_out(d_oe ? dout : ~wd),
		.ack_n(a_oe ? a_o : 1'b1), .bus_error_n_n(e_oe ? e_o : 1'b1));

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (m_we === 1'b1) n_wr++;
		if (w_oe === 1'b1 && w_o === 1'b0) n_wait++;
		if (cycles == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic set_mode(input logic st, input logic ok);
		@(posedge clk);
		#1;
		bus_style_select = st;
		master_clock_ok = ok;
	endtask : set_mode

	task automatic t_regs;
		chk("itc", itc, HBP_IN_TIM_RESET);
		chk("otc", otc, HBP_OUT_TIM_RESET);
		chk("grp", grp, HBP_GRP_RESET);
		set_mode(0, 1);
		hbp_host_model_i.cyc(0, 19'h40284, 2'b00, 16'habcd, 0, rd, ak, be);
		chk("ack", ak, 1'b0);
		chk("wait", n_wait, 32'd1);
		chk("otc", otc, {16'habcd, HBP_OUT_TIM_RESET[15:0]});
		hbp_host_model_i.cyc(1, 19'h40285, 2'b00, 16'h0000, 0, rd, ak, be);
		chk("rd", rd, 16'habcd);
		chk("wait", n_wait, 32'd2);
		chk("w_oe", w_oe, 1'b0);
		chk("d_oe", d_oe, 1'b0);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_lanes;
		set_mode(1, 1);
		hbp_host_model_i.cyc(0, 19'h40202, 2'b01, 16'h5aa5, 0, rd, ak, be);
		chk("ack", ak, 1'b0);
		chk("grp", grp, {HBP_GRP_RESET[31:16], 8'h5a,
			HBP_GRP_RESET[7:0]});
		hbp_host_model_i.cyc(0, 19'h40200, 2'b11, 16'hffff, 0, rd, ak, be);
		hbp_host_model_i.cyc(0, 19'h40200, 2'b10, 16'h5aa5, 0, rd, ak, be);
		chk("grp", grp, {HBP_GRP_RESET[31:24], 8'ha5, 8'h5a,
			HBP_GRP_RESET[7:0]});
		$display("t_lanes done");
	endtask : t_lanes

	task automatic t_errors;
		hbp_host_model_i.cyc(0, 19'h28000, 2'b00, 16'h1111, 0, rd, ak, be);
		chk("bus_error_n", be, 1'b0);
		chk("ack", ak, 1'b0);
		set_mode(0, 1);
		hbp_host_model_i.cyc(0, 19'h40290, 2'b00, 16'h2222, 0, rd, ak, be);
		chk("ack", ak, 1'b1);
		hbp_host_model_i.cyc(1, 19'h38000, 2'b00, 16'h0000, 0, rd, ak, be);
		chk("bus_error_n", be, 1'b0);
		set_mode(0, 0);
		hbp_host_model_i.cyc(0, 19'h40286, 2'b00, 16'h3333, 0, rd, ak, be);
		chk("bus_error_n", be, 1'b0);
		chk("otc", otc, {16'habcd, HBP_OUT_TIM_RESET[15:0]});
		set_mode(0, 1);
		$display("t_errors done");
	endtask : t_errors

	task automatic t_reset;
		@(posedge clk);
		#1;
		power_on_reset_n = 0;
		#2;
		chk("otc", otc, HBP_OUT_TIM_RESET);
		chk("grp", grp, HBP_GRP_RESET);
		repeat (2) @(posedge clk);
		#1;
		power_on_reset_n = 1;
		$display("t_reset done");
	endtask : t_reset

	task automatic t_mem;
		chk("n_wr", n_wr, 32'd0);
		hbp_host_model_i.cyc(0, 19'h00006, 2'b10, 16'h1234, 0, rd, ak, be);
		chk("n_wr", n_wr, 32'd1);
		chk("m_addr", m_addr, 32'h1);
		chk("m_be", m_be, 4'h1);
		chk("m_wd", m_wd, 32'h12341234);
		hbp_host_model_i.cyc(1, 19'h28004, 2'b00, 16'h0000, 0, rd, ak, be);
		chk("rd", rd, 16'h1234);
		chk("m_ro", m_ro, 1'b1);
		chk("m_addr", m_addr, 32'h0a001);
		hbp_host_model_i.cyc(1, 19'h00002, 2'b00, 16'h0000, 0, rd, ak, be);
		chk("rd", rd, 16'h5678);
		hbp_host_model_i.cyc(1, 19'h00000, 2'b01, 16'h0000, 1, rd, ak, be);
		chk("rd", rd[15:8], 8'h12);
		chk("ack", ak, 1'b0);
		$display("t_mem done");
	endtask : t_mem

	task automatic complete_run;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		checked = 0;
		n_mismatch = 0;
		cycles = 0;
		rst = 1;
		power_on_reset_n = 0;
		bus_style_select = 0;
		master_clock_ok = 1;
		mem_rdata = 32'h12345678;
		repeat (16) @(posedge clk);
		#1;
		rst = 0;
		power_on_reset_n = 1;
		t_regs();
		t_lanes();
		t_errors();
		t_reset();
		t_mem();
		complete_run();
	end
endmodule : hbp_host_port_bench

`default_nettype wire
